// ### pkg/chgst_map.vh
// constants for the charger status output block
`ifndef CHGST_MAP_VH
`define CHGST_MAP_VH
`define CHGST_FAULT_PULSE_US 256
`define CHGST_CLK_MHZ 10
`define CHGST_FAULT_PULSE_CYC (`CHGST_FAULT_PULSE_US * `CHGST_CLK_MHZ)
`define CHGST_CNT_W 12
`define CHGST_PORT_UNKNOWN 3'h0
`define CHGST_PORT_SDP 3'h1
`define CHGST_PORT_CDP 3'h2
`define CHGST_PORT_DCP 3'h3
`define CHGST_PORT_NONSTD 3'h4
`define CHGST_ILIM_100MA 2'h0
`define CHGST_ILIM_500MA 2'h1
`define CHGST_ILIM_900MA 2'h2
`define CHGST_ILIM_1500MA 2'h3
`endif

// ### rtl/chgst_pulse_timer.v
// fault pulse timer: one fixed-length pulse per fault, not retriggered
`timescale 1ns/1ps
`include "chgst_map.vh"
module chgst_pulse_timer #(
  parameter CNT_W = `CHGST_CNT_W,
  parameter [CNT_W-1:0] LEN = `CHGST_FAULT_PULSE_CYC
) (
  // clock and reset
  input wire clk_sys,
  input wire rst,
  // control
  input wire fire,
  output reg active_q
);
  reg [CNT_W-1:0] cnt_q;
  always @(posedge clk_sys) begin
    if (rst) begin
      cnt_q <= {CNT_W{1'b0}};
      active_q <= 1'b0;
    end else if (active_q) begin
      // a fault during the pulse neither restarts nor shortens it
      if (cnt_q == LEN - 1'b1) begin
        active_q <= 1'b0;
        cnt_q <= {CNT_W{1'b0}};
      end else begin
        cnt_q <= cnt_q + 1'b1;
      end
    end else if (fire) begin
      active_q <= 1'b1;
      cnt_q <= {CNT_W{1'b0}};
    end
  end
endmodule // chgst_pulse_timer

// ### rtl/chgst_top.v
// charger status outputs: charge status, interrupt, charge active, power good
`timescale 1ns/1ps
`include "chgst_map.vh"
// Behaviour
// - status pin driven low while a charge cycle runs.
// - status pin released when charging done or charger disabled.
// - each fault outside a running pulse gives one 256 us low pulse on the status pin.
// - status enable bit low keeps status pin released always.
// - status pin also low during automatic recharge cycles.
// - interrupt pin variant carries the same signalling as status pin, but ignores the status enable bit.
// - power good pulled low while supply lies inside the valid window.
// - power good released with no supply, or with supply out of window once detection is not busy.
// - power good held low while adapter detection still runs and supply is present.
// - detection classifies ports; non-standard adapters get 500 mA limit.
// - charge active pin low while charging with supply present, no recharge shown.
module chgst_top #(
  parameter CNT_W = `CHGST_CNT_W,
  parameter [CNT_W-1:0] PULSE_CYC = `CHGST_FAULT_PULSE_CYC
) (
  // clock and reset
  input wire clk_sys,
  input wire rst,
  // charger state, same clock
  input wire charging,
  input wire recharging,
  input wire charger_enable,
  input wire fault_event,
  input wire status_enable,
  // supply comparators, asynchronous
  input wire supply_present,
  input wire above_sleep_offset_voltage,
  input wire below_input_overvoltage_threshold,
  // adapter detection results, same clock
  input wire detect_busy,
  input wire detect_done,
  input wire [2:0] detect_port,
  // open-drain pins: out value and active-low enable
  output reg charge_status_o_q,
  output reg charge_status_oe_n_q,
  output reg host_int_o_q,
  output reg host_int_oe_n_q,
  output reg charge_active_n_o_q,
  output reg charge_active_n_oe_n_q,
  output reg supply_valid_n_o_q,
  output reg supply_valid_n_oe_n_q,
  // detection outcome
  output reg [2:0] port_type_q,
  output reg [1:0] input_ilim_q
);
  // ****************************************************************
  // input synchronisers
  // ****************************************************************
  reg [2:0] pres_s_q;
  reg [2:0] slp_s_q;
  reg [2:0] ovp_s_q;
  reg pres_q;
  reg slp_q;
  reg ovp_ok_q;
  always @(posedge clk_sys) begin
    if (rst) begin
      pres_s_q <= 3'h0;
      slp_s_q <= 3'h0;
      ovp_s_q <= 3'h0;
      pres_q <= 1'b0;
      slp_q <= 1'b0;
      ovp_ok_q <= 1'b0;
    end else begin
      pres_s_q <= {pres_s_q[1:0], supply_present};
      slp_s_q <= {slp_s_q[1:0], above_sleep_offset_voltage};
      ovp_s_q <= {ovp_s_q[1:0], below_input_overvoltage_threshold};
      // a level counts only once stages two and three agree
      if (pres_s_q[1] == pres_s_q[2]) pres_q <= pres_s_q[2];
      if (slp_s_q[1] == slp_s_q[2]) slp_q <= slp_s_q[2];
      if (ovp_s_q[1] == ovp_s_q[2]) ovp_ok_q <= ovp_s_q[2];
    end
  end

  // ****************************************************************
  // fault pulse
  // ****************************************************************
  wire pulse_active;
  chgst_pulse_timer #(
    .CNT_W(CNT_W),
    .LEN(PULSE_CYC)
  ) u_pulse (
    .clk_sys(clk_sys),
    .rst(rst),
    .fire(fault_event),
    .active_q(pulse_active)
  );

  // ****************************************************************
  // pin decisions
  // ****************************************************************
  wire chg_run = charger_enable & (charging | recharging);
  wire stat_low = status_enable & (chg_run | pulse_active);
  wire int_low = chg_run | pulse_active;
  // no recharge indication on this pin
  wire act_low = charger_enable & charging & pres_q;
  wire win_ok = pres_q & slp_q & ovp_ok_q;
  // with supply present, detection wins over the window: pin stays low until it is done
  wire pg_low = win_ok | (pres_q & detect_busy);

  always @(posedge clk_sys) begin
    if (rst) begin
      charge_status_o_q <= 1'b0;
      charge_status_oe_n_q <= 1'b1;
      host_int_o_q <= 1'b0;
      host_int_oe_n_q <= 1'b1;
      charge_active_n_o_q <= 1'b0;
      charge_active_n_oe_n_q <= 1'b1;
      supply_valid_n_o_q <= 1'b0;
      supply_valid_n_oe_n_q <= 1'b1;
    end else begin
      // output value is always low; the enable alone pulls the pin
      charge_status_oe_n_q <= ~stat_low;
      host_int_oe_n_q <= ~int_low;
      charge_active_n_oe_n_q <= ~act_low;
      supply_valid_n_oe_n_q <= ~pg_low;
    end
  end

  // ****************************************************************
  // adapter classification
  // ****************************************************************
  always @(posedge clk_sys) begin
    if (rst) begin
      port_type_q <= `CHGST_PORT_UNKNOWN;
      input_ilim_q <= `CHGST_ILIM_100MA;
    end else if (!pres_q) begin
      port_type_q <= `CHGST_PORT_UNKNOWN;
      input_ilim_q <= `CHGST_ILIM_100MA;
    end else if (detect_done) begin
      port_type_q <= detect_port;
      case (detect_port)
        `CHGST_PORT_SDP: input_ilim_q <= `CHGST_ILIM_500MA;
        `CHGST_PORT_CDP: input_ilim_q <= `CHGST_ILIM_1500MA;
        `CHGST_PORT_DCP: input_ilim_q <= `CHGST_ILIM_1500MA;
        `CHGST_PORT_NONSTD: input_ilim_q <= `CHGST_ILIM_500MA;
        default: input_ilim_q <= `CHGST_ILIM_100MA;
      endcase
    end
  end
endmodule // chgst_top

// ### bench/chgst_properties.sv
// assertion checker for the charger status outputs
`timescale 1ns/1ps
module chgst_checker (
  input wire clk_sys, rst, charging, recharging, charger_enable,
  input wire fault_event, status_enable, supply_present, detect_done,
  input wire above_sleep_offset_voltage, below_input_overvoltage_threshold,
  input wire [2:0] detect_port,
  input wire charge_status_oe_n_q, host_int_oe_n_q, supply_valid_n_oe_n_q,
  input wire [1:0] input_ilim_q
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);
  wire ok = supply_present && above_sleep_offset_voltage &&
    below_input_overvoltage_threshold;
  a_status_gated: assert property (!$past(rst) && !$past(status_enable)
    |-> charge_status_oe_n_q) else $error("status driven while disabled");
  a_charge_low: assert property (!$past(rst) &&
    $past(charging && charger_enable && status_enable)
    |-> !charge_status_oe_n_q) else $error("status not low in charge");
  a_recharge_low: assert property (!$past(rst) &&
    $past(recharging && charger_enable && status_enable)
    |-> !charge_status_oe_n_q) else $error("status not low in recharge");
  a_int_mirror: assert property (!$past(rst) && $past(status_enable)
    |-> host_int_oe_n_q == charge_status_oe_n_q) else $error("int differs");
  a_pulse_held: assert property ($past(fault_event, 2) &&
    $past(charger_enable, 2) && !$past(rst, 2) && $past(host_int_oe_n_q)
    |-> !host_int_oe_n_q [*8] ##1 !host_int_oe_n_q [*8])
    else $error("fault pulse too short");
  a_pg_valid: assert property (ok [*6] |=> !supply_valid_n_oe_n_q)
    else $error("power good not low");
  a_pg_absent: assert property (!supply_present [*6]
    |=> supply_valid_n_oe_n_q) else $error("power good not released");
  a_nonstd_limit: assert property (detect_done && detect_port == 3'h4
    |=> input_ilim_q == 2'h1) else $error("wrong limit for adapter");
endmodule // chgst_checker
bind chgst_top chgst_checker u_chk (.*);

// ### bench/chgst_host.sv
// host model: pull-up resistors on the open-drain status pins
`timescale 1ns/1ps
module chgst_host (
  // pin drivers from the charger
  input wire [3:0] pin_o,
  input wire [3:0] pin_oe_n,
  // levels seen by the host
  output wire [3:0] pin_lvl
);
  // a released pin rises through its resistor, it never keeps the old level
  assign pin_lvl = (pin_o & ~pin_oe_n) | pin_oe_n;
endmodule // chgst_host

// ### bench/chgst_top_tb_top.sv
// self-checking testbench for the charger status outputs
`timescale 1ns/1ps
module chgst_top_tb_top;
  reg clk_sys, rst, charging, recharging, charger_enable, fault_event;
  reg status_enable, supply_present, above_sleep_offset_voltage;
  reg below_input_overvoltage_threshold, detect_busy, detect_done;
  reg [2:0] detect_port;
  wire [3:0] o, oe, lvl;
  wire [2:0] pt;
  wire [1:0] ilim;
  integer bad_count = 0, n_tests = 0, i;
  chgst_top #(.PULSE_CYC(12'h010)) u_dut (.*, .charge_status_o_q(o[0]),
    .charge_status_oe_n_q(oe[0]), .host_int_o_q(o[1]),
    .host_int_oe_n_q(oe[1]), .charge_active_n_o_q(o[2]),
    .charge_active_n_oe_n_q(oe[2]), .supply_valid_n_o_q(o[3]),
    .supply_valid_n_oe_n_q(oe[3]), .port_type_q(pt), .input_ilim_q(ilim));
  chgst_host u_host (.pin_o(o), .pin_oe_n(oe), .pin_lvl(lvl));
  task chk(input [3:0] seen, input [3:0] exp, input [95:0] what);
    n_tests = n_tests + 1;
    if (seen !== exp) begin
      bad_count = bad_count + 1;
      $display("BAD %0s exp %h seen %h", what, exp, seen);
    end
  endtask
  task step(input integer n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask
  task complete_run;
    if (bad_count == 0 && n_tests > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task t_charge;
    {charger_enable, status_enable, charging} = 3'h7;
    // charge active pin also waits for the synchronised supply level
    step(5);
    chk(lvl[2:0], 4'h0, "charge");
    {charging, recharging} = 2'h1;
    step(2);
    chk(lvl[2:0], 4'h4, "recharge");
    status_enable = 0;
    step(2);
    chk(lvl[1:0], 4'h1, "stat_off");
    {charger_enable, status_enable} = 2'h1;
    step(2);
    chk(lvl[1:0], 4'h3, "disabled");
    {charger_enable, recharging} = 2'h2;
    step(2);
    chk(lvl[1:0], 4'h3, "done");
  endtask
  task t_fault;
    fault_event = 1;
    step(1);
    fault_event = 0;
    step(2);
    chk(lvl[1:0], 4'h0, "pulse");
    step(5);
    fault_event = 1;
    step(1);
    fault_event = 0;
    step(8);
    chk(lvl[1], 4'h0, "pulse_end");
    step(1);
    chk(lvl[1], 4'h1, "pulse_off");
  endtask
  task t_supply;
    supply_present = 0;
    step(7);
    chk(lvl[3], 4'h1, "no_sup");
    {supply_present, above_sleep_offset_voltage} = 2'h2;
    step(7);
    chk(lvl[3], 4'h1, "low_sup");
    {above_sleep_offset_voltage, below_input_overvoltage_threshold} = 2'h2;
    step(7);
    chk(lvl[3], 4'h1, "ovp");
    detect_busy = 1;
    step(7);
    chk(lvl[3], 4'h0, "detect");
    {detect_busy, below_input_overvoltage_threshold} = 2'h1;
    step(7);
    chk(lvl[3], 4'h0, "valid");
  endtask
  task t_detect;
    for (i = 0; i < 5; i = i + 1) begin
      {detect_done, detect_port} = {1'b1, i[2:0]};
      step(1);
      detect_done = 0;
      step(1);
      chk(pt, i[2:0], "port");
      chk(ilim, (i == 1 || i == 4) ? 4'h1 : (i == 0 ? 4'h0 : 4'h3),
        "ilim_cls");
    end
    chk(ilim, 4'h1, "ilim");
  endtask
  initial begin
    clk_sys = 0;
    forever #50 clk_sys = ~clk_sys;
  end
  initial begin
    // roughly 100 cycles of tests; the limit leaves wide margin
    #300000;
    bad_count = bad_count + 1;
    complete_run;
  end
  initial begin
    {rst, charging, recharging, charger_enable, fault_event} = 5'h10;
    {status_enable, supply_present, above_sleep_offset_voltage} = 3'h7;
    {below_input_overvoltage_threshold, detect_busy, detect_done} = 3'h4;
    detect_port = 3'h0;
    step(12);
    rst = 0;
    t_charge;
    t_fault;
    t_supply;
    t_detect;
    complete_run;
  end
endmodule // chgst_top_tb_top
